// *** src/psam_multiplier.sv ***
// Purpose: pipelined long multiplier, one operand pair in and one result out per cycle
// Assumes: single clock CLK_I at 40 MHz, operands valid every cycle
// Notes:   result is the low bits of the product, eight cycles after entry
// How it works
// RULE1: two unsigned 8-bit operands are multiplied by shift and add, keeping the low 8 bits.
// RULE2: the source offers a pair every cycle and stage one takes it every cycle with no stall.
// RULE3: a pair's result is at the output exactly 8 cycles after it entered stage one.
// RULE4: with the pipe full, a finished product leaves on every cycle.
// RULE5: partial sums move one stage per clock edge, all stages together.
// RULE6: a stage adds its shifted multiplicand only when the multiplier's current low bit is one.
// RULE7: stages shift the multiplier right and the multiplicand left; stage one seeds the sum.
`timescale 1ns/1ps
module psam_multiplier #(
    parameter int W = psam_pkg::OPERAND_W,
    parameter int N = psam_pkg::STAGES
) (
    input  wire logic         CLK_I,
    input  wire logic         RST_I,
    input  wire logic [W-1:0] MULTIPLIER_I,
    input  wire logic [W-1:0] MULTIPLICAND_I,
    output logic      [W-1:0] PRODUCT_O,
    output logic              PRODUCT_VALID_O
);
    // stage k holds sum of first k+1 terms; mplier_reg already shifted for the next stage
    logic [W-1:0] sum_reg    [N];
    logic [W-1:0] mplier_reg [N];
    logic [W-1:0] mcand_reg  [N];
    logic [N-1:0] valid_reg;
    logic [W-1:0] sum_next   [N];
    logic [W-1:0] mplier_in_sh;
    logic [W-1:0] mcand_in_sh;

    function automatic logic [W-1:0] add_term(input logic [W-1:0] s, input logic [W-1:0] a,
                                              input logic [W-1:0] b);
        add_term = a[0] ? W'(s + b) : s; // [RULE6]
    endfunction

    // one bit per stage; bits pushed out of the top are what keep the result to W bits
    function automatic logic [W-1:0] shr1(input logic [W-1:0] v);
        shr1 = v >> 1;
    endfunction

    function automatic logic [W-1:0] shl1(input logic [W-1:0] v);
        shl1 = v << 1;
    endfunction

    // stage one: sum is multiplicand or zero [RULE7]
    assign sum_next[0] = add_term('0, MULTIPLIER_I, MULTIPLICAND_I);
    assign mplier_in_sh = shr1(MULTIPLIER_I);   // [RULE7]
    assign mcand_in_sh  = shl1(MULTIPLICAND_I); // [RULE7]
    for (genvar k = 1; k < N; k++) begin : g_stage
        assign sum_next[k] = add_term(sum_reg[k-1], mplier_reg[k-1], mcand_reg[k-1]); // [RULE1]
    end

    // every stage registers together, no enable: no stall possible [RULE2] [RULE5]
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int k = 0; k < N; k++) begin
                sum_reg[k] <= '0;
            end
        end else begin
            for (int k = 0; k < N; k++) begin
                sum_reg[k] <= sum_next[k];
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int k = 0; k < N; k++) begin
                mplier_reg[k] <= '0;
            end
        end else begin
            mplier_reg[0] <= mplier_in_sh; // [RULE7]
            for (int k = 1; k < N; k++) begin
                mplier_reg[k] <= shr1(mplier_reg[k-1]);
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int k = 0; k < N; k++) begin
                mcand_reg[k] <= '0;
            end
        end else begin
            mcand_reg[0] <= mcand_in_sh; // [RULE7]
            for (int k = 1; k < N; k++) begin
                mcand_reg[k] <= shl1(mcand_reg[k-1]);
            end
        end
    end

    // thermometer of filled stages; no flush control, so valid only drops on reset
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            valid_reg <= '0;
        end else begin
            valid_reg <= {valid_reg[N-2:0], 1'b1}; // [RULE4]
        end
    end

    // last stage drives output directly from its flip-flop [RULE3]
    assign PRODUCT_O       = sum_reg[N-1];
    assign PRODUCT_VALID_O = valid_reg[N-1];

    // reference model: pair captured on entry, product checked at exit
    // kept apart from the stage registers so a shift fault there cannot hide
    logic [W-1:0] a_d [psam_pkg::LATENCY];
    logic [W-1:0] b_d [psam_pkg::LATENCY];
    always_ff @(posedge CLK_I) begin
        a_d[0] <= MULTIPLIER_I;
        b_d[0] <= MULTIPLICAND_I;
        for (int k = 1; k < psam_pkg::LATENCY; k++) begin
            a_d[k] <= a_d[k-1];
            b_d[k] <= b_d[k-1];
        end
    end

    // edges since reset, saturating; counted apart from valid_reg on purpose
    localparam int FILL_W = $clog2(psam_pkg::LATENCY + 1);
    logic [FILL_W-1:0] fill_cnt_reg;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            fill_cnt_reg <= '0;
        end else if (fill_cnt_reg != FILL_W'(psam_pkg::LATENCY)) begin
            fill_cnt_reg <= fill_cnt_reg + FILL_W'(1);
        end
    end

    property p_product_low_bits;
        @(posedge CLK_I) disable iff (RST_I)
        PRODUCT_VALID_O |-> PRODUCT_O == W'(a_d[psam_pkg::LATENCY-1] * b_d[psam_pkg::LATENCY-1]);
    endproperty
    a_product_low_bits: assert property (p_product_low_bits) // [RULE1]
        else $error("product differs from low bits of operand product");

    property p_latency;
        @(posedge CLK_I) disable iff (RST_I)
        PRODUCT_VALID_O |-> PRODUCT_O == W'($past(MULTIPLIER_I, psam_pkg::LATENCY)
                                            * $past(MULTIPLICAND_I, psam_pkg::LATENCY));
    endproperty
    a_latency: assert property (p_latency) // [RULE3]
        else $error("result not at output eight cycles after entry");

    property p_throughput;
        @(posedge CLK_I) disable iff (RST_I)
        PRODUCT_VALID_O |=> PRODUCT_VALID_O [*8];
    endproperty
    a_throughput: assert property (p_throughput) // [RULE4]
        else $error("output valid dropped once pipeline was full");

    property p_valid_at_fill;
        @(posedge CLK_I) disable iff (RST_I)
        PRODUCT_VALID_O == (fill_cnt_reg == FILL_W'(psam_pkg::LATENCY));
    endproperty
    a_valid_at_fill: assert property (p_valid_at_fill) // [RULE3]
        else $error("output valid not exactly eight edges after reset");

    property p_fill;
        @(posedge CLK_I) disable iff (RST_I)
        $rose(valid_reg[0]) |-> ##7 $rose(PRODUCT_VALID_O);
    endproperty
    a_fill: assert property (p_fill) // [RULE5]
        else $error("pipeline fill not one stage per cycle");

    property p_accept;
        @(posedge CLK_I) disable iff (RST_I)
        valid_reg[0] |-> mplier_reg[0] == ($past(MULTIPLIER_I) >> 1)
                         && mcand_reg[0] == W'($past(MULTIPLICAND_I) << 1);
    endproperty
    a_accept: assert property (p_accept) // [RULE2]
        else $error("first stage did not take the offered pair");

    property p_first_sum;
        @(posedge CLK_I) disable iff (RST_I)
        valid_reg[0] |-> sum_reg[0] == ($past(MULTIPLIER_I[0]) ? $past(MULTIPLICAND_I) : '0);
    endproperty
    a_first_sum: assert property (p_first_sum) // [RULE7]
        else $error("first stage sum wrong");

    property p_skip_zero;
        @(posedge CLK_I) disable iff (RST_I)
        valid_reg[1] && !$past(mplier_reg[0][0]) |-> sum_reg[1] == $past(sum_reg[0]);
    endproperty
    a_skip_zero: assert property (p_skip_zero) // [RULE6]
        else $error("stage added although multiplier bit was zero");

    property p_add_one;
        @(posedge CLK_I) disable iff (RST_I)
        valid_reg[1] && $past(mplier_reg[0][0])
            |-> sum_reg[1] == W'($past(sum_reg[0]) + $past(mcand_reg[0]));
    endproperty
    a_add_one: assert property (p_add_one) // [RULE6]
        else $error("stage did not add although multiplier bit was one");

    property p_last_pass;
        @(posedge CLK_I) disable iff (RST_I)
        valid_reg[N-1] && !$past(mplier_reg[N-2][0]) |-> PRODUCT_O == $past(sum_reg[N-2]);
    endproperty
    a_last_pass: assert property (p_last_pass) // [RULE5]
        else $error("last stage did not take the sum of the stage before");

    property p_shift_pass;
        @(posedge CLK_I) disable iff (RST_I)
        valid_reg[1] |-> mplier_reg[1] == ($past(MULTIPLIER_I, 2) >> 2);
    endproperty
    a_shift_pass: assert property (p_shift_pass) // [RULE7]
        else $error("multiplier not shifted right per stage");

    property p_mcand_pass;
        @(posedge CLK_I) disable iff (RST_I)
        valid_reg[1] |-> mcand_reg[1] == W'($past(MULTIPLICAND_I, 2) << 2);
    endproperty
    a_mcand_pass: assert property (p_mcand_pass) // [RULE7]
        else $error("multiplicand not shifted left per stage");

    property p_mplier_out;
        @(posedge CLK_I) disable iff (RST_I)
        PRODUCT_VALID_O |-> mplier_reg[N-1] == ($past(MULTIPLIER_I, N) >> N);
    endproperty
    a_mplier_out: assert property (p_mplier_out) // [RULE7]
        else $error("multiplier not fully shifted out at last stage");
endmodule

// *** src/psam_pkg.sv ***
// Purpose: shared constants for the pipelined shift-add multiplier
// Assumes: unsigned operands, low half of the product kept
// Notes:   widths and depth are defaults of the top module parameters
package psam_pkg;
    localparam int OPERAND_W = 8;
    localparam int STAGES    = 8;
    localparam int LATENCY   = 8;
endpackage

// *** tb/psam_multiplier_tb.sv ***
// Purpose: self-checking bench for the pipelined multiplier
// Assumes: 40 MHz clock, reset held 8 cycles
// Notes:   expected products come from a history of the pairs taken
`timescale 1ns/1ps
module psam_multiplier_tb;
    logic       clk = 1'b0;
    logic       rst;
    logic [7:0] a, b, p;
    logic       v;
    logic [7:0] ha[$], hb[$];
    int         n_fail = 0;
    int         tests_run = 0;
    always #12.5 clk = ~clk;
    psam_source src (.clk_i(clk), .rst_i(rst), .a_o(a), .b_o(b));
    psam_multiplier dut (.CLK_I(clk), .RST_I(rst), .MULTIPLIER_I(a), .MULTIPLICAND_I(b),
                         .PRODUCT_O(p), .PRODUCT_VALID_O(v));
    always @(posedge clk) if (!rst) begin
        ha.push_back(a);
        hb.push_back(b);
    end
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one cycle: valid only once a pair has had 8 edges, product of that pair
    task automatic step();
        int n;
        @(negedge clk);
        n = ha.size();
        check("valid", {7'h00, n >= 8}, {7'h00, v});
        if (n >= 8) check("product", 8'(ha[n-8] * hb[n-8]), p);
    endtask
    task automatic test_fill();
        @(posedge clk) rst <= 1'b1;
        repeat (8) @(posedge clk);
        check("reset product", 8'h00, p);
        check("reset valid", 8'h00, {7'h00, v});
        ha.delete();
        hb.delete();
        rst <= 1'b0;
        repeat (10) step();
        $display("test fill done");
    endtask
    task automatic test_stream();
        repeat (300) step();
        $display("test stream done");
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        test_fill();
        test_stream();
        test_fill();
        summarize();
    end
    initial begin
        #(25 * 2000);
        n_fail++;
        summarize();
    end
endmodule

// *** tb/psam_source.sv ***
// Purpose: upstream model feeding one operand pair on every clock
// Assumes: reset loads the first pair 3 and 5
// Notes:   values step by odd constants so low bits keep toggling
`timescale 1ns/1ps
module psam_source (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    output logic      [7:0] a_o,
    output logic      [7:0] b_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            a_o <= 8'h03;
            b_o <= 8'h05;
        end else begin
            a_o <= a_o + 8'h35;
            b_o <= b_o + 8'he5;
        end
    end
endmodule
